// ===== pao_pkg.sv
// shared constants for the pipelined converter output interface
package pao_pkg;

    // word and pipeline shape
    localparam int DATA_W         = 12;
    localparam int STAGE_COUNT    = 12;
    localparam int RES_W          = 16;
    localparam int ACC_W          = 14;
    localparam int LATENCY_CYCLES = 7;
    localparam int RES_SHIFT      = 2;

    // residue scale: full scale is VREF_RES, comparators sit at +/- quarter scale
    localparam logic signed [RES_W-1:0] VREF_RES   = 16'sh2000;
    localparam logic signed [RES_W-1:0] THRESH_RES = 16'sh0800;

    // offset binary coding
    localparam logic [DATA_W-1:0] CODE_MID = 12'h800;
    localparam logic [DATA_W-1:0] CODE_MAX = 12'hfff;
    localparam logic [DATA_W-1:0] CODE_MIN = 12'h000;
    localparam logic signed [12:0] DIFF_MAX = 13'sh07ff;
    localparam logic signed [12:0] DIFF_MIN = -13'sh0800;

    // sample clock limits the capture side keeps
    localparam int SYS_CLK_HZ        = 200000000;
    localparam int SAMPLE_CLK_MAX_HZ = 20000000;
    localparam int SAMPLE_CLK_MIN_HZ = 100000;
    localparam int SAMPLE_MIN_CYCLES = SYS_CLK_HZ / SAMPLE_CLK_MAX_HZ;

    // reset values
    localparam logic [DATA_W-1:0] RST_CODE = CODE_MID;
    localparam logic [DATA_W-1:0] RST_OE   = 12'h000;

endpackage : pao_pkg

// ===== pao_stage.sv
// one pipeline stage: two comparators, residue doubling, weighted code
`timescale 1ns/100ps
module pao_stage #(
    parameter int WEIGHT = 1
) (
    // clock and reset
    input  wire logic                                   clk,
    input  wire logic                                   rst_n,
    // half-cycle advance
    input  wire logic                                   adv,
    // residue and partial code from the previous stage
    input  wire logic signed [pao_pkg::RES_W-1:0]       res_in,
    input  wire logic signed [pao_pkg::ACC_W-1:0]       acc_in,
    // residue and partial code to the next stage
    output logic signed [pao_pkg::RES_W-1:0]            res_q,
    output logic signed [pao_pkg::ACC_W-1:0]            acc_q
);

    localparam logic signed [pao_pkg::ACC_W-1:0] W_ACC = pao_pkg::ACC_W'(WEIGHT);

    logic                                  cmp_hi;
    logic                                  cmp_lo;
    logic signed [pao_pkg::RES_W-1:0]      res_dbl;
    logic signed [pao_pkg::RES_W-1:0]      res_d;
    logic signed [pao_pkg::ACC_W-1:0]      acc_d;

    always_comb begin
        cmp_hi  = res_in > pao_pkg::THRESH_RES;
        cmp_lo  = res_in < -pao_pkg::THRESH_RES;
        res_dbl = pao_pkg::RES_W'(res_in <<< 1);
        // digit 2 or 0 moves the residue back by one reference step; digit 1 keeps the doubled residue
        if (cmp_hi) begin
            res_d = pao_pkg::RES_W'(res_dbl - pao_pkg::VREF_RES);
            acc_d = pao_pkg::ACC_W'(acc_in + W_ACC);
        end else if (cmp_lo) begin
            res_d = pao_pkg::RES_W'(res_dbl + pao_pkg::VREF_RES);
            acc_d = pao_pkg::ACC_W'(acc_in - W_ACC);
        end else begin
            res_d = res_dbl;
            acc_d = acc_in;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_q <= '0;
            acc_q <= '0;
        end else if (adv) begin
            res_q <= res_d;
            acc_q <= acc_d;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_RESIDUE_BOUND: assert property (
        res_q <= pao_pkg::VREF_RES && res_q >= -pao_pkg::VREF_RES)
        else $error("stage residue left full scale");

    AST_ONE_DIGIT_STEP: assert property (
        adv |=> (acc_q == $past(acc_in) || acc_q == $past(acc_in) + W_ACC || acc_q == $past(acc_in) - W_ACC))
        else $error("stage code moved by more than its weight");

endmodule : pao_stage

// ===== pao_adc_top.sv
// digital side of the twelve stage pipelined converter and its output bus
`timescale 1ns/100ps
module pao_adc_top (
    // system clock and reset
    input  wire logic                          CLK,
    input  wire logic                          RST_N,
    // converter controls from the capture side
    input  wire logic                          SAMPLE_CLK,
    input  wire logic                          OUTPUT_ENABLE_N,
    input  wire logic                          SHUTDOWN_REQUEST,
    // differential input, as unsigned codes per leg
    input  wire logic [pao_pkg::DATA_W-1:0]    POSITIVE_ANALOG_IN,
    input  wire logic [pao_pkg::DATA_W-1:0]    NEGATIVE_ANALOG_IN,
    // three-state sample bus
    output logic [pao_pkg::DATA_W-1:0]         SAMPLE_BITS_O,
    output logic [pao_pkg::DATA_W-1:0]         SAMPLE_BITS_OE
);

    logic [1:0]                                rst_sync_q;
    logic                                      rst_n_s;
    logic                                      sclk_q;
    logic                                      rise_ev;
    logic                                      fall_ev;
    logic                                      adv;
    logic signed [12:0]                        diff_raw;
    logic signed [pao_pkg::DATA_W-1:0]         diff_clamp;
    logic signed [pao_pkg::RES_W-1:0]          th_d;
    logic signed [pao_pkg::RES_W-1:0]          th_q;
    logic signed [pao_pkg::RES_W-1:0]          stage_res [pao_pkg::STAGE_COUNT+1];
    logic signed [pao_pkg::ACC_W-1:0]          stage_acc [pao_pkg::STAGE_COUNT+1];
    logic signed [pao_pkg::ACC_W-1:0]          half_acc;
    logic signed [pao_pkg::ACC_W-1:0]          code_wide;
    logic [pao_pkg::DATA_W-1:0]                corr_d;
    logic [pao_pkg::DATA_W-1:0]                corr_q;

    // reset release through two flops
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n_s = rst_sync_q[1];

    // sample clock phase tracking
    always_ff @(posedge CLK or negedge rst_n_s) begin
        if (!rst_n_s) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= SAMPLE_CLK;
        end
    end

    // shutdown masks every edge, so the whole pipeline freezes in place
    assign rise_ev = SAMPLE_CLK & ~sclk_q & ~SHUTDOWN_REQUEST;
    assign fall_ev = ~SAMPLE_CLK & sclk_q & ~SHUTDOWN_REQUEST;
    // a lone fall dropped by shutdown skews one word; park the clock low first
    assign adv     = rise_ev | fall_ev;

    // differential value, clamped to the convertible span
    always_comb begin
        diff_raw = $signed({1'b0, POSITIVE_ANALOG_IN}) - $signed({1'b0, NEGATIVE_ANALOG_IN});
        if (diff_raw > pao_pkg::DIFF_MAX) begin
            diff_clamp = pao_pkg::DATA_W'(pao_pkg::DIFF_MAX);
        end else if (diff_raw < pao_pkg::DIFF_MIN) begin
            diff_clamp = pao_pkg::DATA_W'(pao_pkg::DIFF_MIN);
        end else begin
            diff_clamp = pao_pkg::DATA_W'(diff_raw);
        end
        th_d = pao_pkg::RES_W'(pao_pkg::RES_W'(diff_clamp) <<< pao_pkg::RES_SHIFT);
    end

    // track and hold
    always_ff @(posedge CLK or negedge rst_n_s) begin
        if (!rst_n_s) begin
            th_q <= '0;
        end else if (rise_ev) begin
            th_q <= th_d;
        end
    end

    assign stage_res[0] = th_q;
    assign stage_acc[0] = '0;

    // twelve stages, weights from the most significant down
    generate
        for (genvar i = 0; i < pao_pkg::STAGE_COUNT; i++) begin : g_stage
            pao_stage #(
                .WEIGHT (1 << (pao_pkg::STAGE_COUNT - 1 - i))
            ) u_stage (
                .clk    (CLK),
                .rst_n  (rst_n_s),
                .adv    (adv),
                .res_in (stage_res[i]),
                .acc_in (stage_acc[i]),
                .res_q  (stage_res[i+1]),
                .acc_q  (stage_acc[i+1])
            );
        end
    endgenerate

    // error correction: the sum carries one extra half-lsb of redundancy
    always_comb begin
        half_acc  = pao_pkg::ACC_W'((stage_acc[pao_pkg::STAGE_COUNT] + 14'sh0001) >>> 1);
        code_wide = pao_pkg::ACC_W'(half_acc + $signed({2'h0, pao_pkg::CODE_MID}));
        if (code_wide > $signed({2'h0, pao_pkg::CODE_MAX})) begin
            corr_d = pao_pkg::CODE_MAX;
        end else if (code_wide < 14'sh0000) begin
            corr_d = pao_pkg::CODE_MIN;
        end else begin
            corr_d = code_wide[pao_pkg::DATA_W-1:0];
        end
    end

    // correction register on the falling phase
    always_ff @(posedge CLK or negedge rst_n_s) begin
        if (!rst_n_s) begin
            corr_q <= pao_pkg::RST_CODE;
        end else if (fall_ev) begin
            corr_q <= corr_d;
        end
    end

    // output latch on the rising phase; frozen while shut down
    always_ff @(posedge CLK or negedge rst_n_s) begin
        if (!rst_n_s) begin
            SAMPLE_BITS_O <= pao_pkg::RST_CODE;
        end else if (rise_ev) begin
            SAMPLE_BITS_O <= corr_q;
        end
    end

    // bus drivers follow the enable one clock later
    always_ff @(posedge CLK or negedge rst_n_s) begin
        if (!rst_n_s) begin
            SAMPLE_BITS_OE <= pao_pkg::RST_OE;
        end else begin
            SAMPLE_BITS_OE <= {pao_pkg::DATA_W{~OUTPUT_ENABLE_N}};
        end
    end

    // checking helpers: ideal code shadowed through seven rises
    logic signed [pao_pkg::DATA_W-1:0]         shadow_q [pao_pkg::LATENCY_CYCLES];
    logic [pao_pkg::DATA_W-1:0]                exp_lo;
    logic [pao_pkg::DATA_W-1:0]                exp_hi;

    always_ff @(posedge CLK or negedge rst_n_s) begin
        if (!rst_n_s) begin
            for (int k = 0; k < pao_pkg::LATENCY_CYCLES; k++) begin
                shadow_q[k] <= '0;
            end
        end else if (rise_ev) begin
            shadow_q[0] <= diff_clamp;
            for (int k = 1; k < pao_pkg::LATENCY_CYCLES; k++) begin
                shadow_q[k] <= shadow_q[k-1];
            end
        end
    end

    always_comb begin
        exp_lo = shadow_q[pao_pkg::LATENCY_CYCLES-1] ^ pao_pkg::CODE_MID;
        exp_hi = (exp_lo == pao_pkg::CODE_MAX) ? pao_pkg::CODE_MAX : pao_pkg::DATA_W'(exp_lo + 12'h001);
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (!rst_n_s);

    AST_RELEASE_BUS: assert property (
        OUTPUT_ENABLE_N |=> SAMPLE_BITS_OE == 12'h000)
        else $error("bus still driven with enable high");

    AST_DRIVE_BUS: assert property (
        !OUTPUT_ENABLE_N |=> SAMPLE_BITS_OE == 12'hfff)
        else $error("bus not driven with enable low");

    AST_SHUTDOWN_STOP: assert property (
        SHUTDOWN_REQUEST |=> $stable(stage_res[1]) && $stable(th_q))
        else $error("pipeline moved during shutdown");

    AST_SHUTDOWN_HOLD: assert property (
        SHUTDOWN_REQUEST |=> $stable(SAMPLE_BITS_O))
        else $error("output changed during shutdown");

    AST_SEVEN_CYCLE_RESULT: assert property (
        rise_ev |=> SAMPLE_BITS_O >= $past(exp_lo) && SAMPLE_BITS_O <= $past(exp_hi))
        else $error("result does not match sample from seven cycles earlier");

    AST_HALF_CYCLE_ONLY: assert property (
        !adv |=> $stable(stage_res[1]) && $stable(stage_acc[1]))
        else $error("stage advanced without a clock phase");

    AST_SAMPLE_ON_RISE: assert property (
        fall_ev |=> $stable(th_q))
        else $error("sample taken on falling phase");

    AST_OUTPUT_ON_RISE_ONLY: assert property (
        !rise_ev |=> $stable(SAMPLE_BITS_O))
        else $error("output word moved without a sample clock rise");

    AST_CORRECT_ON_FALL: assert property (
        !fall_ev |=> $stable(corr_q))
        else $error("correction register moved without a falling phase");

endmodule : pao_adc_top

// ===== pao_capture.sv
// capture side model: sample clock source and bus reader
`timescale 1ns/100ps
module pao_capture (
    // clock
    input  wire logic                       clk,
    // sample clock shape
    input  wire logic                       run,
    input  wire logic [7:0]                 hi_len,
    input  wire logic [7:0]                 lo_len,
    // converter bus
    input  wire logic [pao_pkg::DATA_W-1:0] bits_o,
    input  wire logic [pao_pkg::DATA_W-1:0] bits_oe,
    output logic                            sclk,
    output logic [pao_pkg::DATA_W-1:0]      bus
);
    int                         cnt;
    logic [pao_pkg::DATA_W-1:0] last;

    initial begin
        sclk = 1'b0;
        cnt  = 0;
        last = '0;
    end

    // stops only in the low phase, so no half is ever cut short
    always @(negedge clk) begin
        if (cnt > 1) cnt <= cnt - 1;
        else if (sclk) begin
            sclk <= 1'b0;
            cnt  <= int'(lo_len);
        end else if (run) begin
            sclk <= 1'b1;
            cnt  <= int'(hi_len);
        end
    end

    // released lines show the inverse of the last driven level
    always_comb begin
        for (int i = 0; i < pao_pkg::DATA_W; i++) bus[i] = bits_oe[i] ? bits_o[i] : ~last[i];
    end

    always @(posedge clk) begin
        for (int i = 0; i < pao_pkg::DATA_W; i++) if (bits_oe[i]) last[i] <= bits_o[i];
    end
endmodule : pao_capture

// ===== tb.sv
// self-checking bench for the pipelined converter output interface
`timescale 1ns/100ps
module tb;
    logic                       clk, rst_n, oe_n, shut, run, live;
    logic                       sclk, sclk_s, oen_s, shut_s, ev_q, ev_d;
    logic [7:0]                 hi_len, lo_len;
    logic [pao_pkg::DATA_W-1:0] pos, neg, bits_o, bits_oe, bus, o_prev, lo_e, hi_e, rd;
    logic [pao_pkg::DATA_W-1:0] q_lo[$];
    logic [pao_pkg::DATA_W-1:0] c_pos[8] = '{12'hfff, 12'h000, 12'h800, 12'h7ff, 12'h000, 12'h123, 12'hfff, 12'h001};
    logic [pao_pkg::DATA_W-1:0] c_neg[8] = '{12'h000, 12'hfff, 12'h800, 12'h000, 12'h800, 12'h123, 12'h800, 12'h000};
    logic [31:0]                seed;
    int                         err_total, n_checks;

    pao_adc_top dut (.CLK(clk), .RST_N(rst_n), .SAMPLE_CLK(sclk), .OUTPUT_ENABLE_N(oe_n),
        .SHUTDOWN_REQUEST(shut), .POSITIVE_ANALOG_IN(pos), .NEGATIVE_ANALOG_IN(neg),
        .SAMPLE_BITS_O(bits_o), .SAMPLE_BITS_OE(bits_oe));
    pao_capture cap (.clk(clk), .run(run), .hi_len(hi_len), .lo_len(lo_len),
        .bits_o(bits_o), .bits_oe(bits_oe), .sclk(sclk), .bus(bus));

    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : next_rand

    // expected low code; the quantiser may land one above it
    function automatic logic [11:0] code_of(input logic [11:0] p, input logic [11:0] n);
        int d;
        d = int'(p) - int'(n);
        if (d > 2047) d = 2047;
        if (d < -2048) d = -2048;
        return pao_pkg::CODE_MID + 12'(d);
    endfunction : code_of

    task automatic fail(input string msg);
        err_total++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask : fail

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out

    // mode 1 toggles the enable, mode 2 walks the corner codes
    task automatic stream(input int n, input int mode, input string name);
        logic [31:0] r;
        repeat (n) begin
            @(negedge clk);
            r = next_rand();
            pos = (mode == 2) ? c_pos[r[26:24]] : r[11:0];
            neg = (mode == 2) ? c_neg[r[26:24]] : r[23:12];
            if (mode == 1) oe_n = r[24];
            if (r[31:28] == 4'h0) begin
                hi_len = 8'h05 + 8'(r[27:25]);
                lo_len = 8'h05 + 8'(r[3:1]);
            end
        end
        $display("test %s done", name);
    endtask : stream

    // driver side notes the code of every sample the converter takes
    always @(posedge clk) begin
        sclk_s <= sclk;
        oen_s  <= oe_n;
        shut_s <= shut;
        ev_q   <= live && sclk && !sclk_s && !shut;
        ev_d   <= ev_q;
        if (live && sclk && !sclk_s && !shut) q_lo.push_back(code_of(pos, neg));
    end

    always @(negedge clk) begin
        if (live) begin
            n_checks++;
            if (bits_oe !== {12{~oen_s}}) fail("bus enable mismatch");
            if (shut_s && bits_o !== o_prev) fail("output moved in shutdown");
            if (ev_d) begin
                lo_e = q_lo.pop_front();
                hi_e = (lo_e == pao_pkg::CODE_MAX) ? lo_e : lo_e + 12'h001;
                rd = (bits_oe === 12'hfff) ? bus : bits_o;
                n_checks++;
                if (rd !== lo_e && rd !== hi_e) fail("sample code mismatch");
            end
        end
        o_prev <= bits_o;
    end

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        #200000;
        fail("run timed out");
        close_out();
    end

    initial begin
        {rst_n, oe_n, shut, run, live, sclk_s, oen_s, shut_s, ev_q, ev_d} = '0;
        pos = '0;
        neg = '0;
        hi_len = 8'h05;
        lo_len = 8'h05;
        seed = 32'h00016076;
        err_total = 0;
        n_checks = 0;
        repeat (7) q_lo.push_back(pao_pkg::CODE_MID);
        repeat (16) @(negedge clk);
        n_checks++;
        if (bits_o !== pao_pkg::RST_CODE || bits_oe !== pao_pkg::RST_OE) fail("reset values");
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        live = 1'b1;
        run = 1'b1;
        stream(600, 0, "random stream");
        stream(400, 2, "corner codes");
        stream(600, 1, "enable toggling");
        run = 1'b0;
        stream(30, 0, "clock parked");
        shut = 1'b1;
        run = 1'b1;
        stream(80, 1, "shutdown running clock");
        run = 1'b0;
        stream(30, 1, "shutdown parked");
        shut = 1'b0;
        stream(3, 0, "wake");
        oe_n = 1'b0;
        run = 1'b1;
        stream(300, 0, "after shutdown");
        close_out();
    end
endmodule : tb
